// ### cb_secondary_regs.sv
/*
 Card-side secondary status, bus numbers and latency timer of one socket
 function, reached through byte-wide configuration reads and writes.
 Assumes error events are one-cycle pulses from the card-side cycle engine
 and that config accesses are synchronous to clock_in.
*/
// Functional notes
// - Writing one clears an error flag; writing zero leaves it.
// - Secondary status at 16h, resets to 0200h.
// - Bit 15 sets on card-side address or data parity error.
// - Bit 14 sets on card system error; device never drives it.
// - Bit 13 sets when our card-side master cycle master-aborts.
// - Bit 12 sets when our card-side cycle gets a target abort.
// - Bit 11 sets when we target-abort as card-side target.
// - Bits 10 to 9 read fixed 01b, medium decode timing.
// - Bit 8 sets on parity error report while master, if enabled.
// - Bit 7 reads zero; no fast back-to-back acceptance.
// - Bit 6 reads zero; no user features.
// - Bit 5 reads zero; card clock never above 33 MHz.
// - Bits 4 to 0 read zero.
// - Primary bus number at 18h, reset 00h, driven out but not used in the route decision.
// - Card bus number at 19h, reset 00h, per function.
// - Highest downstream bus number at 1Ah, reset 00h, per function.
// - Latency timer at 1Bh counts card clocks from frame start.
// - On expiry before done, end after the next data phase.
`timescale 1ns/1ps
`default_nettype none
`include "cb_secondary_regs.svh"
module cb_secondary_regs
#(
   // Latency counter width; must reach the largest timer setting
   parameter int LAT_COUNT_WIDTH = 8
)
(
   // Clock and reset
   input wire logic clock_in,
   input wire logic nrst_in,
   // Configuration access, one byte per cycle
   input wire logic cfg_write_in,
   input wire logic cfg_read_in,
   input wire logic [7:0] cfg_offset_in,
   input wire logic [7:0] cfg_wdata_in,
   output logic [7:0] cfg_rdata_out,
   output logic cfg_hit_out,
   // Card-side events
   input wire logic card_side_parity_detected_in,
   input wire logic card_system_error_seen_in,
   input wire logic card_master_abort_received_in,
   input wire logic card_target_abort_received_in,
   input wire logic card_target_abort_signaled_in,
   input wire logic card_perr_seen_in,
   input wire logic card_is_master_in,
   input wire logic parity_response_enable_in,
   // Initiator timing
   input wire logic card_frame_start_in,
   input wire logic card_data_phase_done_in,
   input wire logic card_transaction_done_in,
   output logic card_stop_after_phase_out,
   // Configuration forwarding
   input wire logic [7:0] cfg_target_bus_in,
   output cb_secondary_pkg::cfg_route_t cfg_route_out,
   output logic [7:0] primary_bus_number_out
);
   import cb_secondary_pkg::*;

   // A narrower counter could never reach a large timer setting
   if (LAT_COUNT_WIDTH < 8)
   begin : g_bad_width
      $error("latency counter narrower than timer");
   end

   logic [4:0] err_flags;
   logic [4:0] next_err_flags;
   logic dpar_flag;
   logic next_dpar_flag;
   logic [7:0] primary_bus_number;
   logic [7:0] card_side_bus_number;
   logic [7:0] highest_downstream_bus_number;
   logic [7:0] card_side_latency_timer;
   logic [7:0] next_primary;
   logic [7:0] next_card_bus;
   logic [7:0] next_highest;
   logic [7:0] next_latency;
   logic [LAT_COUNT_WIDTH-1:0] lat_cycles;
   logic [LAT_COUNT_WIDTH-1:0] next_lat_cycles;
   lat_state_t lat_state;
   lat_state_t next_lat_state;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   cfg_route_t route;
   cfg_route_t next_route;
   logic [15:0] status_word;
   logic [4:0] err_events;
   logic [4:0] err_clear;
   logic wr_status_hi;

   // Flags at bits 15..11 in order
   assign err_events = {card_side_parity_detected_in,
                        card_system_error_seen_in,
                        card_master_abort_received_in,
                        card_target_abort_received_in,
                        card_target_abort_signaled_in};
   assign wr_status_hi = cfg_write_in && (cfg_offset_in == (`SEC_STATUS_OFFSET + 8'h01));
   assign err_clear = wr_status_hi ? cfg_wdata_in[7:3] : 5'h00;

   // Constant fields read back fixed
   assign status_word = {err_flags, `DEVSEL_CODE, dpar_flag, 8'h00};

   // One set-over-clear cell per error flag at bits 15..11
   for (genvar g = 0; g < 5; g++)
   begin : g_err_flag
      // Set wins so no event is lost to a racing clear
      assign next_err_flags[g] = err_events[g] | (err_flags[g] & ~err_clear[g]);
   end

   always_comb
   begin
      next_dpar_flag = dpar_flag;
      if (cfg_write_in && cfg_offset_in == (`SEC_STATUS_OFFSET + 8'h01) && cfg_wdata_in[0])
      begin
         next_dpar_flag = 1'b0;
      end
      if (card_perr_seen_in && card_is_master_in && parity_response_enable_in)
      begin
         next_dpar_flag = 1'b1;
      end
   end

   always_comb
   begin
      next_primary = primary_bus_number;
      next_card_bus = card_side_bus_number;
      next_highest = highest_downstream_bus_number;
      next_latency = card_side_latency_timer;
      if (cfg_write_in)
      begin
         unique case (cfg_offset_in)
            `PRIMARY_BUS_OFFSET: next_primary = cfg_wdata_in;
            `CARD_BUS_OFFSET: next_card_bus = cfg_wdata_in;
            `HIGHEST_BUS_OFFSET: next_highest = cfg_wdata_in;
            `CARD_LAT_OFFSET: next_latency = cfg_wdata_in;
            default: next_primary = primary_bus_number;
         endcase
      end
   end

   always_comb
   begin
      next_rdata = rdata;
      if (cfg_read_in)
      begin
         unique case (cfg_offset_in)
            `SEC_STATUS_OFFSET: next_rdata = status_word[7:0];
            `SEC_STATUS_OFFSET + 8'h01: next_rdata = status_word[15:8];
            `PRIMARY_BUS_OFFSET: next_rdata = primary_bus_number;
            `CARD_BUS_OFFSET: next_rdata = card_side_bus_number;
            `HIGHEST_BUS_OFFSET: next_rdata = highest_downstream_bus_number;
            `CARD_LAT_OFFSET: next_rdata = card_side_latency_timer;
            default: next_rdata = 8'h00;
         endcase
      end
   end

   // Forwarding decision; a zero card bus number means not yet configured
   always_comb
   begin
      next_route = cfg_not_ours;
      if (card_side_bus_number != 8'h00 && cfg_target_bus_in == card_side_bus_number)
      begin
         next_route = cfg_type0;
      end
      else if (card_side_bus_number != 8'h00 && cfg_target_bus_in > card_side_bus_number &&
               cfg_target_bus_in <= highest_downstream_bus_number)
      begin
         next_route = cfg_type1;
      end
   end

   // Latency count; zero setting expires at once, hence advice of 20h or more
   always_comb
   begin
      next_lat_state = lat_state;
      next_lat_cycles = lat_cycles;
      unique case (lat_state)
         lat_idle:
            if (card_frame_start_in)
            begin
               next_lat_cycles = '0;
               next_lat_state = lat_count;
            end
         lat_count:
            if (card_transaction_done_in)
            begin
               next_lat_state = lat_idle;
            end
            else if (lat_cycles >= LAT_COUNT_WIDTH'(card_side_latency_timer))
            begin
               next_lat_state = lat_expired;
            end
            else
            begin
               next_lat_cycles = lat_cycles + LAT_COUNT_WIDTH'(1);
            end
         lat_expired:
            if (card_transaction_done_in || card_data_phase_done_in)
            begin
               next_lat_state = lat_idle;
            end
      endcase
   end

   // Status flags; all clear so status reads 0200h after reset
   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         err_flags <= 5'h00;
         dpar_flag <= 1'b0;
      end
      else
      begin
         err_flags <= next_err_flags;
         dpar_flag <= next_dpar_flag;
      end
   end

   // Bus numbers and latency setting
   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         primary_bus_number <= `BUS_NUMBER_RESET;
         card_side_bus_number <= `BUS_NUMBER_RESET;
         highest_downstream_bus_number <= `BUS_NUMBER_RESET;
         card_side_latency_timer <= `CARD_LAT_RESET;
      end
      else
      begin
         primary_bus_number <= next_primary;
         card_side_bus_number <= next_card_bus;
         highest_downstream_bus_number <= next_highest;
         card_side_latency_timer <= next_latency;
      end
   end

   // Read data holds until the next read
   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         rdata <= 8'h00;
      end
      else
      begin
         rdata <= next_rdata;
      end
   end

   // Registered route costs one cycle but keeps the compare off the output
   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         route <= cfg_not_ours;
      end
      else
      begin
         route <= next_route;
      end
   end

   // Latency count
   always_ff @(posedge clock_in)
   begin
      if (!nrst_in)
      begin
         lat_cycles <= '0;
         lat_state <= lat_idle;
      end
      else
      begin
         lat_cycles <= next_lat_cycles;
         lat_state <= next_lat_state;
      end
   end

   assign cfg_rdata_out = rdata;
   assign cfg_hit_out = (cfg_read_in || cfg_write_in) &&
                        (cfg_offset_in >= `SEC_STATUS_OFFSET) && (cfg_offset_in <= `CARD_LAT_OFFSET) &&
                        (cfg_offset_in != 8'h18 - 8'h01) ? 1'b1 :
                        (cfg_read_in || cfg_write_in) && (cfg_offset_in == 8'h17);
   assign card_stop_after_phase_out = (lat_state == lat_expired);
   assign cfg_route_out = route;
   assign primary_bus_number_out = primary_bus_number;
endmodule : cb_secondary_regs
`default_nettype wire

// ### cb_secondary_regs.svh
/*
 Register offsets, field positions, reset values and fixed codes of the
 card-side secondary register bank. Assumes byte offsets in config space.
*/
`ifndef CB_SECONDARY_REGS_SVH
`define CB_SECONDARY_REGS_SVH
`define SEC_STATUS_OFFSET 8'h16
`define PRIMARY_BUS_OFFSET 8'h18
`define CARD_BUS_OFFSET 8'h19
`define HIGHEST_BUS_OFFSET 8'h1a
`define CARD_LAT_OFFSET 8'h1b
`define SEC_STATUS_RESET 16'h0200
`define BUS_NUMBER_RESET 8'h00
`define CARD_LAT_RESET 8'h00
`define PARITY_BIT 15
`define SYSERR_BIT 14
`define MABORT_BIT 13
`define TABORT_RX_BIT 12
`define TABORT_TX_BIT 11
`define DEVSEL_LSB 9
`define DEVSEL_CODE 2'h1
`define DPAR_BIT 8
`endif

// ### cb_secondary_pkg.sv
/*
 Types shared by the card-side secondary register bank.
 Assumes the _regs header supplies all numeric constants.
*/
package cb_secondary_pkg;
   typedef enum logic [1:0] {cfg_not_ours, cfg_type0, cfg_type1} cfg_route_t;
   typedef enum {lat_idle, lat_count, lat_expired} lat_state_t;
endpackage : cb_secondary_pkg

// ### cb_secondary_regs_sva.sv
/* Concurrent checks on the secondary register bank ports.
 Assumes a bind to every cb_secondary_regs instance. */
`timescale 1ns/1ps
`default_nettype none
module cb_secondary_regs_sva
(
   // Clock, reset and access
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic cfg_write_in,
   input wire logic cfg_read_in,
   input wire logic [7:0] cfg_offset_in,
   input wire logic [7:0] cfg_wdata_in,
   input wire logic [7:0] cfg_rdata_out,
   input wire logic cfg_hit_out,
   // Card side
   input wire logic card_side_parity_detected_in,
   input wire logic card_master_abort_received_in,
   input wire logic card_frame_start_in,
   input wire logic card_data_phase_done_in,
   input wire logic card_stop_after_phase_out,
   input wire logic [7:0] primary_bus_number_out
);
   default clocking @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);
   a_low_byte_zero:
   assert property (cfg_read_in && cfg_offset_in == 8'h16 |=> cfg_rdata_out == 8'h00)
      else $error("status low byte not zero");
   a_devsel_fixed:
   assert property (cfg_read_in && cfg_offset_in == 8'h17 |=> cfg_rdata_out[2:1] == 2'b01)
      else $error("decode timing code wrong");
   a_hit_window:
   assert property (cfg_hit_out == ((cfg_read_in || cfg_write_in)
      && cfg_offset_in inside {[8'h16:8'h1b]})) else $error("hit flag wrong");
   a_parity_sticks:
   assert property (card_side_parity_detected_in ##1 (cfg_read_in && !cfg_write_in
      && cfg_offset_in == 8'h17) |=> cfg_rdata_out[7]) else $error("parity flag lost");
   a_mabort_sticks:
   assert property (card_master_abort_received_in ##1 (cfg_read_in && !cfg_write_in
      && cfg_offset_in == 8'h17) |=> cfg_rdata_out[5]) else $error("abort flag lost");
   a_primary_copy:
   assert property (cfg_write_in && cfg_offset_in == 8'h18
      |=> primary_bus_number_out == $past(cfg_wdata_in)) else $error("primary bus wrong");
   a_stop_release:
   assert property (card_stop_after_phase_out && card_data_phase_done_in
      && !card_frame_start_in |=> !card_stop_after_phase_out) else $error("stop held");
   a_reset_clear:
   assert property (disable iff (1'b0) !nrst_in |=> cfg_rdata_out == 8'h00
      && primary_bus_number_out == 8'h00 && !card_stop_after_phase_out)
      else $error("reset values wrong");
endmodule : cb_secondary_regs_sva
bind cb_secondary_regs cb_secondary_regs_sva i_sva (.clock_in, .nrst_in, .cfg_write_in,
   .cfg_read_in, .cfg_offset_in, .cfg_wdata_in, .cfg_rdata_out, .cfg_hit_out,
   .card_side_parity_detected_in, .card_master_abort_received_in, .card_frame_start_in,
   .card_data_phase_done_in, .card_stop_after_phase_out, .primary_bus_number_out);
`default_nettype wire

// ### cb_card_model.sv
/* Card-side partner: one-cycle event pulses on request.
 Assumes callers sit 1 ns after a rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module cb_card_model
(
   // Clock
   input wire logic clock_in,
   // Event pulses
   output logic [7:0] ev_out
);
   initial ev_out = 8'h00;
   // Delay n models a slow card
   task automatic fire(input int idx, input int n);
      repeat (n)
      begin
         @(posedge clock_in);
         #1;
      end
      ev_out[idx] = 1'b1;
      @(posedge clock_in);
      #1;
      ev_out[idx] = 1'b0;
   endtask : fire
endmodule : cb_card_model
`default_nettype wire

// ### tb_top.sv
/* Self-checking bench for the secondary register bank.
 Assumes the card model drives all event inputs except frame start, which the bench drives. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
 $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   import cb_secondary_pkg::*;
   logic clock_in = 1'b0, nrst_in = 1'b0, cfg_write_in = 1'b0, cfg_read_in = 1'b0;
   logic card_is_master_in = 1'b0, parity_response_enable_in = 1'b0, card_frame_start_in = 1'b0;
   logic [7:0] cfg_offset_in = 8'h00, cfg_wdata_in = 8'h00, cfg_target_bus_in = 8'h00;
   logic [7:0] cfg_rdata_out, primary_bus_number_out, ev, sh = 8'h00;
   logic [7:0] bus [4] = '{default: 8'h00};
   logic cfg_hit_out, card_stop_after_phase_out;
   logic [31:0] rnd = 32'h061b6275;
   cfg_route_t cfg_route_out;
   int mismatches = 0, checks_done = 0, cycles = 0, k;
   cb_secondary_regs i_dut (.clock_in, .nrst_in, .cfg_write_in, .cfg_read_in, .cfg_offset_in,
      .cfg_wdata_in, .cfg_rdata_out, .cfg_hit_out, .card_side_parity_detected_in(ev[0]),
      .card_system_error_seen_in(ev[1]), .card_master_abort_received_in(ev[2]),
      .card_target_abort_received_in(ev[3]), .card_target_abort_signaled_in(ev[4]),
      .card_perr_seen_in(ev[5]), .card_is_master_in, .parity_response_enable_in,
      .card_frame_start_in, .card_data_phase_done_in(ev[6]),
      .card_transaction_done_in(ev[7]), .card_stop_after_phase_out, .cfg_target_bus_in,
      .cfg_route_out, .primary_bus_number_out);
   cb_card_model i_card (.clock_in, .ev_out(ev));
   initial forever #5 clock_in = ~clock_in;
   always @(posedge clock_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         finish_test();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] exp_rd(input logic [7:0] o);
      if (o == 8'h17) return sh | 8'h02;
      if (o >= 8'h18 && o <= 8'h1b) return bus[o[1:0]];
      return 8'h00;
   endfunction : exp_rd
   task automatic tick(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : tick
   task automatic wr(input logic [7:0] o, input logic [7:0] d);
      cfg_offset_in = o;
      cfg_wdata_in = d;
      cfg_write_in = 1'b1;
      tick(1);
      cfg_write_in = 1'b0;
      if (o == 8'h17) sh = sh & ~(d & 8'hf9);
      if (o >= 8'h18 && o <= 8'h1b) bus[o[1:0]] = d;
   endtask : wr
   task automatic rd(input logic [7:0] o);
      cfg_offset_in = o;
      cfg_read_in = 1'b1;
      tick(1);
      cfg_read_in = 1'b0;
      `CHK(cfg_rdata_out, exp_rd(o))
   endtask : rd
   task automatic finish_test();
      $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : finish_test
   initial
   begin
      tick(2);
      nrst_in = 1'b1;
      for (int o = 8'h15; o <= 8'h1c; o++) rd(8'(o));
      for (int o = 8'h16; o <= 8'h1b; o++)
      begin
         rnd = lfsr(rnd);
         wr(8'(o), rnd[7:0]);
         rd(8'(o));
      end
      `CHK(primary_bus_number_out, bus[0])
      for (int i = 0; i < 5; i++)
      begin
         i_card.fire(i, i);
         sh[7 - i] = 1'b1;
         rd(8'h17);
         wr(8'h17, ~(8'h80 >> i));
         rd(8'h17);
         wr(8'h17, 8'h80 >> i);
         rd(8'h17);
      end
      for (int c = 0; c < 8; c++)
      begin
         card_is_master_in = c[1];
         parity_response_enable_in = c[2];
         if (c[0]) i_card.fire(5, 0);
         else tick(1);
         sh[0] = (c == 7);
         rd(8'h17);
         wr(8'h17, 8'h01);
      end
      // Same-edge set and clear
      fork
         i_card.fire(0, 0);
         wr(8'h17, 8'h80);
      join
      sh[7] = 1'b1;
      rd(8'h17);
      wr(8'h19, 8'h05);
      wr(8'h1a, 8'h08);
      for (int t = 0; t < 11; t++)
      begin
         cfg_target_bus_in = 8'(t);
         tick(1);
         `CHK(cfg_route_out, t == 5 ? cfg_type0 : t > 5 && t <= 8 ? cfg_type1 : cfg_not_ours)
      end
      wr(8'h19, 8'h00);
      cfg_target_bus_in = 8'h00;
      tick(1);
      `CHK(cfg_route_out, cfg_not_ours)
      wr(8'h1b, 8'h20);
      card_frame_start_in = 1'b1;
      tick(1);
      card_frame_start_in = 1'b0;
      for (k = 0; k < 60 && !card_stop_after_phase_out; k++) tick(1);
      // Count 0 one edge after frame start, 20h reached 32 edges on, stop one edge later
      `CHK(k, 33)
      i_card.fire(6, 1);
      tick(1);
      `CHK(card_stop_after_phase_out, 1'b0)
      card_frame_start_in = 1'b1;
      tick(1);
      card_frame_start_in = 1'b0;
      i_card.fire(7, 3);
      tick(40);
      `CHK(card_stop_after_phase_out, 1'b0)
      nrst_in = 1'b0;
      tick(2);
      nrst_in = 1'b1;
      sh = 8'h00;
      bus = '{default: 8'h00};
      rd(8'h17);
      rd(8'h1a);
      finish_test();
   end
endmodule : tb_top
`default_nettype wire
